// >>> clock_gate_consts.svh
// register offsets, field positions, reset values and masks of the clock gate block
`ifndef CLOCK_GATE_CONSTS_SVH
`define CLOCK_GATE_CONSTS_SVH

`define ADDR_W            16
`define OFS_SYS_SET       16'h0000
`define OFS_SYS_CLEAR     16'h0004
`define OFS_SYS_STATE     16'h0008
`define OFS_PER_SET_LO    16'h0010
`define OFS_PER_CLEAR_LO  16'h0014
`define OFS_PER_STATE_LO  16'h0018
`define OFS_MAIN_OSC      16'h0020
`define OFS_MAIN_FREQ     16'h0024
`define OFS_PLL_SETUP     16'h0028
`define OFS_MCK_SELECT    16'h0030
`define OFS_USB_SETUP     16'h0038
`define OFS_PCK_ZERO      16'h0040
`define OFS_PCK_ONE       16'h0044
`define OFS_PCK_TWO       16'h0048
`define OFS_IRQ_SET       16'h0060
`define OFS_IRQ_CLEAR     16'h0064
`define OFS_CTRL_STATE    16'h0068
`define OFS_IRQ_STATE     16'h006c
`define OFS_WAKE_SRC      16'h0070
`define OFS_WAKE_POL      16'h0074
`define OFS_FAULT_CLEAR   16'h0078
`define OFS_GUARD_MODE    16'h00e4
`define OFS_GUARD_STATE   16'h00e8
`define OFS_PER_SET_HI    16'h0100
`define OFS_PER_CLEAR_HI  16'h0104
`define OFS_PER_STATE_HI  16'h0108
`define OFS_RC_TRIM       16'h0110
`define OFS_PLL_LIMIT     16'h0130

`define USB_PORT_BIT      7
`define PCK_ZERO_BIT      8
`define GUARD_ENABLE_BIT  0
`define GUARD_VIOL_BIT    0
`define GUARD_SRC_LSB     8

`define SYS_STATE_MASK    32'h0000_0780
`define PER_LO_MASK       32'hffff_ff80
`define PER_HI_MASK       32'h0000_003f

`define RST_SYS_STATE     32'h0000_0001
`define RST_PER_STATE     32'h0000_0000
`define RST_MAIN_OSC      32'h0000_0008
`define RST_PLL_SETUP     32'h0000_3f00
`define RST_MCK_SELECT    32'h0000_0001
`define RST_CTRL_STATE    32'h0001_0008
`define RST_PLL_LIMIT     32'h07ff_07ff
`define RST_RC_TRIM       32'h0040_4040
`define RST_ZERO          32'h0000_0000

`define RW_COUNT          13

`endif

// >>> clock_gate_pkg.sv
// types and decode helpers of the clock gate block
`include "clock_gate_consts.svh"
package clock_gate_pkg;

  typedef logic [`ADDR_W-1:0] addr_t;

  // bus channel state, gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESP = 2'b01
  } busState_e;

  // byte enables widened to a bit mask
  function automatic logic [31:0] strbMask(input logic [3:0] strb);
    strbMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strbMask

  // registers that the write guard covers
  function automatic logic isGuarded(input addr_t a);
    case (a)
      `OFS_SYS_SET, `OFS_SYS_CLEAR, `OFS_PER_SET_LO, `OFS_PER_CLEAR_LO,
      `OFS_MAIN_OSC, `OFS_PLL_SETUP, `OFS_MCK_SELECT, `OFS_USB_SETUP,
      `OFS_PCK_ZERO, `OFS_PCK_ONE, `OFS_PCK_TWO, `OFS_WAKE_SRC, `OFS_WAKE_POL,
      `OFS_PER_SET_HI, `OFS_PER_CLEAR_HI, `OFS_RC_TRIM,
      `OFS_PLL_LIMIT: isGuarded = 1'b1;
      default:        isGuarded = 1'b0;
    endcase
  endfunction : isGuarded

  // write-only registers, which read as zero
  function automatic logic isWriteOnly(input addr_t a);
    case (a)
      `OFS_SYS_SET, `OFS_SYS_CLEAR, `OFS_PER_SET_LO, `OFS_PER_CLEAR_LO,
      `OFS_IRQ_SET, `OFS_IRQ_CLEAR, `OFS_FAULT_CLEAR, `OFS_PER_SET_HI,
      `OFS_PER_CLEAR_HI: isWriteOnly = 1'b1;
      default:           isWriteOnly = 1'b0;
    endcase
  endfunction : isWriteOnly

  // slot of a plain read/write register in the storage array
  function automatic logic [3:0] rwSlot(input addr_t a);
    case (a)
      `OFS_MAIN_OSC:   rwSlot = 4'h0;
      `OFS_MAIN_FREQ:  rwSlot = 4'h1;
      `OFS_PLL_SETUP:  rwSlot = 4'h2;
      `OFS_MCK_SELECT: rwSlot = 4'h3;
      `OFS_USB_SETUP:  rwSlot = 4'h4;
      `OFS_PCK_ZERO:   rwSlot = 4'h5;
      `OFS_PCK_ONE:    rwSlot = 4'h6;
      `OFS_PCK_TWO:    rwSlot = 4'h7;
      `OFS_WAKE_SRC:   rwSlot = 4'h8;
      `OFS_WAKE_POL:   rwSlot = 4'h9;
      `OFS_RC_TRIM:    rwSlot = 4'ha;
      `OFS_PLL_LIMIT:  rwSlot = 4'hb;
      `OFS_GUARD_MODE: rwSlot = 4'hc;
      default:         rwSlot = 4'hf;
    endcase
  endfunction : rwSlot

  // reset value of each storage slot
  function automatic logic [31:0] rwReset(input int slot);
    case (slot)
      0:       rwReset = `RST_MAIN_OSC;
      2:       rwReset = `RST_PLL_SETUP;
      3:       rwReset = `RST_MCK_SELECT;
      10:      rwReset = `RST_RC_TRIM;
      11:      rwReset = `RST_PLL_LIMIT;
      default: rwReset = `RST_ZERO;
    endcase
  endfunction : rwReset

endpackage : clock_gate_pkg

// >>> reg_access_if.sv
// register access strobes between the bus slave and the register core
`timescale 1ns/1ps
interface reg_access_if;
  import clock_gate_pkg::*;
  logic        wrEn;
  addr_t       wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        wrHit;
  logic        rdEn;
  addr_t       rdAddr;
  logic [31:0] rdData;
  logic        rdHit;

  modport bus  (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
                input  wrHit, rdData, rdHit);
  modport core (input  wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
                output wrHit, rdData, rdHit);
endinterface : reg_access_if

// >>> axi_lite_slave.sv
// axi4-lite slave turning bus transfers into one-cycle register strobes
`timescale 1ns/1ps
`include "clock_gate_consts.svh"
module axi_lite_slave
  import clock_gate_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire addr_t       awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire addr_t       araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  reg_access_if.bus        regs
);
  busState_e   wrStateQ, rdStateQ;
  logic        awHeldQ, wHeldQ;
  addr_t       awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;

  // strobes toward the core; read address is taken straight off the channel
  assign regs.wrEn   = (wrStateQ == ST_IDLE) && awHeldQ && wHeldQ;
  assign regs.wrAddr = awAddrQ;
  assign regs.wrData = wDataQ;
  assign regs.wrStrb = wStrbQ;
  assign regs.rdEn   = arvalid && arready;
  assign regs.rdAddr = araddr;

  // write side: address and data caught in either order, then one response
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrStateQ <= ST_IDLE;
      awHeldQ  <= 1'b0;
      wHeldQ   <= 1'b0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      awAddrQ  <= '0;
      wDataQ   <= '0;
      wStrbQ   <= '0;
      bvalid   <= 1'b0;
      bresp    <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        awAddrQ <= {awaddr[`ADDR_W-1:2], 2'b00};
        awHeldQ <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
        wHeldQ <= 1'b1;
        wready <= 1'b0;
      end
      unique case (wrStateQ)
        ST_IDLE: if (regs.wrEn) begin
          awHeldQ  <= 1'b0;
          wHeldQ   <= 1'b0;
          bvalid   <= 1'b1;
          bresp    <= regs.wrHit ? 2'b00 : 2'b10; // unmapped: slave error
          wrStateQ <= ST_RESP;
        end
        ST_RESP: if (bready) begin
          bvalid   <= 1'b0;
          awready  <= 1'b1;
          wready   <= 1'b1;
          wrStateQ <= ST_IDLE;
        end
      endcase
    end
  end

  // read side: data sampled in the cycle the address is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdStateQ <= ST_IDLE;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= '0;
      rresp    <= 2'b00;
    end else begin
      unique case (rdStateQ)
        ST_IDLE: if (regs.rdEn) begin
          arready  <= 1'b0;
          rvalid   <= 1'b1;
          rdata    <= regs.rdData;
          rresp    <= regs.rdHit ? 2'b00 : 2'b10;
          rdStateQ <= ST_RESP;
        end
        ST_RESP: if (rready) begin
          rvalid   <= 1'b0;
          arready  <= 1'b1;
          rdStateQ <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : axi_lite_slave

// >>> clock_gate_bits.sv
// set/clear clock enable bits with a mask of implemented positions
`timescale 1ns/1ps
module clock_gate_bits #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] IMPL_MASK = 32'hffff_ffff
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        setEn,
  input  wire logic        clrEn,
  input  wire logic [31:0] bits,
  output logic [31:0]      stateQ
);
  // ones set or clear, zeros and unimplemented positions hold
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stateQ <= RESET_VAL;
    end else if (setEn) begin
      stateQ <= stateQ | (bits & IMPL_MASK);
    end else if (clrEn) begin
      stateQ <= stateQ & ~(bits & IMPL_MASK);
    end
  end

  a_fixed_bits_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (stateQ & ~IMPL_MASK) == (RESET_VAL & ~IMPL_MASK))
    else $error("unimplemented clock bit changed");
endmodule : clock_gate_bits

// >>> clock_gate_register_interface.sv
// register interface of the clock gate controller behind an axi4-lite slave
// How it works
// - a one in bit 7 of system_clock_set starts the 48 MHz usb port clock.
// - ones in bits 8..10 of system_clock_set start programmable outputs 0..2.
// - a one in bit 7 of system_clock_clear stops the usb port clock.
// - ones in bits 8..10 of system_clock_clear stop programmable outputs 0..2.
// - bit 7 of system_clock_state shows whether the usb port clock runs.
// - bits 8..10 of system_clock_state show which programmable outputs run.
// - ones in bits 7..31 of peripheral_clock_set_low start those peripheral clocks.
// - set or clear bits of peripherals that do not exist are ignored.
// - clock set and clear writes are dropped while the write guard is enabled.
// - system_clock_state reads 0x0000_0001 after reset.
// - peripheral_clock_state_low reads 0x0000_0000 after reset.
// - ones in bits 7..31 of peripheral_clock_clear_low stop those clocks.
// - a dropped write sets the violation flag and records the offset.
// - reading write_guard_state clears the violation flag unless a write is dropped in the same cycle.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "clock_gate_consts.svh"
module clock_gate_register_interface
  import clock_gate_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire addr_t       awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire addr_t       araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             usbPortClockEn,
  output logic [2:0]       progClockOutEn,
  output logic [31:0]      peripheralClockEnLow,
  output logic [31:0]      peripheralClockEnHigh,
  output logic             writeGuardViolation
);
  reg_access_if regs ();

  // checks sample on the system clock and sleep in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic [31:0] sysStateQ;
  logic [31:0] perLoQ;
  logic [31:0] perHiQ;
  logic [31:0] rwQ [0:`RW_COUNT-1];
  logic        guardViolQ;
  addr_t       guardSrcQ;
  logic [31:0] wrBits;
  logic        guardOn;
  logic        blocked;
  logic        accept;
  logic        guardRead;
  logic [3:0]  wrSlot;

  // protection level bits are not used by this block
  logic unusedProt;
  assign unusedProt = ^{awprot, arprot};

  axi_lite_slave u_bus (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .regs    (regs)
  );

  // write qualification against the guard
  assign wrBits    = regs.wrData & strbMask(regs.wrStrb);
  assign guardOn   = rwQ[4'hc][`GUARD_ENABLE_BIT];
  assign blocked   = regs.wrEn && guardOn && isGuarded(regs.wrAddr);
  assign accept    = regs.wrEn && !blocked;
  assign wrSlot    = rwSlot(regs.wrAddr);
  assign guardRead = regs.rdEn && ({regs.rdAddr[`ADDR_W-1:2], 2'b00} == `OFS_GUARD_STATE);

  // system clocks: usb port clock and three programmable outputs
  clock_gate_bits #(
    .RESET_VAL (`RST_SYS_STATE),
    .IMPL_MASK (`SYS_STATE_MASK)
  ) u_sys (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .setEn   (accept && regs.wrAddr == `OFS_SYS_SET),
    .clrEn   (accept && regs.wrAddr == `OFS_SYS_CLEAR),
    .bits    (wrBits),
    .stateQ  (sysStateQ)
  );

  // peripheral clocks 7..31
  clock_gate_bits #(
    .RESET_VAL (`RST_PER_STATE),
    .IMPL_MASK (`PER_LO_MASK)
  ) u_per_lo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .setEn   (accept && regs.wrAddr == `OFS_PER_SET_LO),
    .clrEn   (accept && regs.wrAddr == `OFS_PER_CLEAR_LO),
    .bits    (wrBits),
    .stateQ  (perLoQ)
  );

  // peripheral clocks of the upper bank
  clock_gate_bits #(
    .RESET_VAL (`RST_PER_STATE),
    .IMPL_MASK (`PER_HI_MASK)
  ) u_per_hi (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .setEn   (accept && regs.wrAddr == `OFS_PER_SET_HI),
    .clrEn   (accept && regs.wrAddr == `OFS_PER_CLEAR_HI),
    .bits    (wrBits),
    .stateQ  (perHiQ)
  );

  // clock enables leave straight from the state flops
  assign usbPortClockEn        = sysStateQ[`USB_PORT_BIT];
  assign progClockOutEn        = sysStateQ[`PCK_ZERO_BIT+2:`PCK_ZERO_BIT];
  assign peripheralClockEnLow  = perLoQ;
  assign peripheralClockEnHigh = perHiQ;
  assign writeGuardViolation   = guardViolQ;

  // plain read/write storage, byte lanes honoured
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `RW_COUNT; i++) begin
        rwQ[i] <= rwReset(i);
      end
    end else if (accept && wrSlot != 4'hf) begin
      rwQ[wrSlot] <= (rwQ[wrSlot] & ~strbMask(regs.wrStrb)) | wrBits;
    end
  end

  // violation flag and source; a new violation wins over the read clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      guardViolQ <= 1'b0;
      guardSrcQ  <= '0;
    end else if (blocked) begin
      guardViolQ <= 1'b1;
      guardSrcQ  <= regs.wrAddr;
    end else if (guardRead) begin
      guardViolQ <= 1'b0;
    end
  end

  // address map of writes: write-only and read/write offsets answer okay, even when blocked
  always_comb begin
    regs.wrHit = isWriteOnly(regs.wrAddr) || (wrSlot != 4'hf);
  end

  // read mux; write-only offsets read zero with no side effect
  always_comb begin
    regs.rdHit  = 1'b1;
    regs.rdData = 32'h0000_0000;
    case ({regs.rdAddr[`ADDR_W-1:2], 2'b00})
      `OFS_SYS_STATE:    regs.rdData = sysStateQ;
      `OFS_PER_STATE_LO: regs.rdData = perLoQ;
      `OFS_PER_STATE_HI: regs.rdData = perHiQ;
      `OFS_CTRL_STATE:   regs.rdData = `RST_CTRL_STATE;
      `OFS_IRQ_STATE:    regs.rdData = 32'h0000_0000;
      `OFS_GUARD_STATE:  regs.rdData = {8'h00, guardSrcQ, 7'h00, guardViolQ};
      default: begin
        if (isWriteOnly({regs.rdAddr[`ADDR_W-1:2], 2'b00})) begin
          regs.rdData = 32'h0000_0000;
        end else if (rwSlot({regs.rdAddr[`ADDR_W-1:2], 2'b00}) != 4'hf) begin
          regs.rdData = rwQ[rwSlot({regs.rdAddr[`ADDR_W-1:2], 2'b00})];
        end else begin
          regs.rdHit = 1'b0; // unmapped
        end
      end
    endcase
  end

  // accepted writes to the system and low peripheral banks, as the checks see them
  logic sysSetW, sysClrW, perSetW, perClrW;
  assign sysSetW = accept && regs.wrAddr == `OFS_SYS_SET;
  assign sysClrW = accept && regs.wrAddr == `OFS_SYS_CLEAR;
  assign perSetW = accept && regs.wrAddr == `OFS_PER_SET_LO;
  assign perClrW = accept && regs.wrAddr == `OFS_PER_CLEAR_LO;

  a_usb_set_on: assert property (sysSetW && wrBits[7] |=> usbPortClockEn)
    else $error("usb port clock not started");

  a_pck_set_on: assert property (
    sysSetW |=> (progClockOutEn & $past(wrBits[10:8])) == $past(wrBits[10:8]))
    else $error("programmable output not started");

  a_usb_clr_off: assert property (sysClrW && wrBits[7] |=> !usbPortClockEn)
    else $error("usb port clock not stopped");

  a_pck_clr_off: assert property (
    sysClrW |=> (progClockOutEn & $past(wrBits[10:8])) == 3'b000)
    else $error("programmable output not stopped");

  a_usb_state_read: assert property (
    regs.rdEn && regs.rdAddr == `OFS_SYS_STATE |=> rdata[7] == $past(usbPortClockEn))
    else $error("usb clock state misread");

  a_pck_state_read: assert property (
    regs.rdEn && regs.rdAddr == `OFS_SYS_STATE |=> rdata[10:8] == $past(progClockOutEn))
    else $error("programmable clock state misread");

  a_per_set_on: assert property (
    perSetW |=> (perLoQ & $past(wrBits) & `PER_LO_MASK) == ($past(wrBits) & `PER_LO_MASK))
    else $error("peripheral clock not started");

  a_guard_blocks: assert property (
    regs.wrEn && guardOn && regs.wrAddr inside {`OFS_SYS_SET, `OFS_SYS_CLEAR}
      |=> $stable(sysStateQ))
    else $error("guarded write changed clocks");

  a_viol_records: assert property (
    blocked |=> guardViolQ && guardSrcQ == $past(regs.wrAddr))
    else $error("violation not recorded");

  a_read_clears: assert property (
    guardRead && !blocked ##1 !regs.wrEn[*2] |-> !guardViolQ)
    else $error("violation flag survived read");

  a_sys_hold: assert property (
    !(sysSetW || sysClrW) |=> $stable(sysStateQ))
    else $error("system clock bit moved without write");

  a_wo_read_zero: assert property (
    regs.rdEn && isWriteOnly(regs.rdAddr) |=> rdata == 32'h0000_0000 && rresp == 2'b00)
    else $error("write-only register read non-zero");

  // zero bits of a set or clear write leave their clocks alone
  a_usb_set_zero: assert property (
    sysSetW && !wrBits[7] |=> usbPortClockEn == $past(usbPortClockEn))
    else $error("usb clock moved on zero set bit");

  a_usb_clr_zero: assert property (
    sysClrW && !wrBits[7] |=> usbPortClockEn == $past(usbPortClockEn))
    else $error("usb clock moved on zero clear bit");

  a_sys_set_zero: assert property (
    sysSetW |=> (sysStateQ & ~$past(wrBits)) == ($past(sysStateQ) & ~$past(wrBits)))
    else $error("system clock moved on zero set bit");

  a_sys_clr_zero: assert property (
    sysClrW |=> (sysStateQ & ~$past(wrBits)) == ($past(sysStateQ) & ~$past(wrBits)))
    else $error("system clock moved on zero clear bit");

  // peripheral banks, then the fixed bits of system_clock_state
  a_per_set_zero: assert property (
    perSetW |=> (perLoQ & ~$past(wrBits)) == ($past(perLoQ) & ~$past(wrBits)))
    else $error("peripheral clock moved on zero set bit");

  a_per_clr_off: assert property (
    perClrW |=> (perLoQ & $past(wrBits) & `PER_LO_MASK) == 32'h0000_0000)
    else $error("peripheral clock not stopped");

  a_per_hold: assert property (
    !(perSetW || perClrW) |=> $stable(perLoQ))
    else $error("peripheral clock moved without write");

  a_per_lo_fixed: assert property ((perLoQ & ~`PER_LO_MASK) == 32'h0000_0000)
    else $error("missing low peripheral running");

  a_per_hi_fixed: assert property ((perHiQ & ~`PER_HI_MASK) == 32'h0000_0000)
    else $error("missing high peripheral running");

  a_per_state_read: assert property (
    regs.rdEn && regs.rdAddr == `OFS_PER_STATE_LO |=> rdata == $past(perLoQ))
    else $error("peripheral state misread");

  a_per_hi_read: assert property (
    regs.rdEn && regs.rdAddr == `OFS_PER_STATE_HI |=> rdata == $past(perHiQ))
    else $error("upper peripheral state misread");

  a_sys_base_bit: assert property (sysStateQ[0] == 1'b1)
    else $error("constant state bit lost");

  a_sys_fixed: assert property ((sysStateQ & ~`SYS_STATE_MASK) == `RST_SYS_STATE)
    else $error("unused system state bit moved");

  // write guard and its violation record
  a_blocked_hold: assert property (
    blocked |=> $stable(sysStateQ) && $stable(perLoQ) && $stable(perHiQ))
    else $error("blocked write changed a clock");

  a_blocked_okay: assert property (
    blocked |=> bvalid && bresp == 2'b00)
    else $error("blocked write not answered okay");

  a_viol_holds: assert property (
    guardViolQ && !guardRead |=> guardViolQ)
    else $error("violation flag lost without read");

  a_viol_quiet: assert property (
    !guardViolQ && !blocked |=> !guardViolQ)
    else $error("violation flag set without block");

  a_viol_src_hold: assert property (
    !blocked |=> $stable(guardSrcQ))
    else $error("violation source moved");

  a_read_old_flag: assert property (
    guardRead |=> rdata[0] == $past(guardViolQ))
    else $error("violation flag read after clear");

  a_viol_src_read: assert property (
    guardRead |=> rdata[23:8] == $past(guardSrcQ))
    else $error("violation source misread");

  // main scenarios reached
  c_usb_started:  cover property (sysSetW && wrBits[7] ##1 usbPortClockEn);
  c_guard_block:  cover property (blocked ##[1:20] guardRead);
  c_per_cleared:  cover property (perSetW ##[1:20] accept && regs.wrAddr == `OFS_PER_CLEAR_LO);
  c_flag_cleared: cover property (guardRead && guardViolQ);
  c_reserved_rd:  cover property (regs.rdEn && !regs.rdHit);
endmodule : clock_gate_register_interface

// >>> tb_clock_gate_register_interface.sv
// self-checking testbench of the clock gate register interface
`timescale 1ns/1ps
`include "clock_gate_consts.svh"
module tb_clock_gate_register_interface
  import clock_gate_pkg::*;
;
  logic        clk_sys;
  logic        reset_n;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  addr_t       awaddr, araddr;
  logic [31:0] wdata, rdata, perLow, perHigh;
  logic [3:0]  wstrb;
  logic [3:0]  strbUse = 4'hf;
  logic [1:0]  bresp, rresp;
  logic        usbEn, guardViol;
  logic [2:0]  progEn;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  clock_gate_register_interface clock_gate_register_interface_inst (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .usbPortClockEn(usbEn), .progClockOutEn(progEn),
    .peripheralClockEnLow(perLow), .peripheralClockEnHigh(perHigh),
    .writeGuardViolation(guardViol)
  );

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // hang guard: a run far past its expected length counts as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // write one word; each channel released at its own handshake
  task automatic axi_write(input addr_t a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= strbUse;
    bready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  // read one word; rready held until rvalid is sampled
  task automatic axi_read(input addr_t a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // state registers and enables straight after reset
  task automatic test_reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(`OFS_SYS_STATE, d, r);
    check(d, 32'h0000_0001);
    axi_read(`OFS_PER_STATE_LO, d, r);
    check(d, 32'h0000_0000);
    check({28'h0, usbEn, progEn}, 32'h0000_0000);
  endtask : test_reset_values

  // system clock set, partial clear, zero write, state readback
  task automatic test_system_clocks();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(`OFS_SYS_SET, 32'h0000_0780, r);
    check({28'h0, usbEn, progEn}, 32'h0000_000f);
    axi_write(`OFS_SYS_CLEAR, 32'h0000_0100, r);
    check({29'h0, progEn}, 32'h0000_0006);
    axi_write(`OFS_SYS_SET, 32'h0000_0000, r);
    axi_read(`OFS_SYS_STATE, d, r);
    check(d, 32'h0000_0681);
    axi_write(`OFS_SYS_CLEAR, 32'h0000_0680, r);
    check({28'h0, usbEn, progEn}, 32'h0000_0000);
    strbUse = 4'h2;
    axi_write(`OFS_SYS_SET, 32'hffff_ffff, r);
    strbUse = 4'hf;
    check({28'h0, usbEn, progEn}, 32'h0000_0007);
  endtask : test_system_clocks

  // peripheral banks, unimplemented positions ignored
  task automatic test_peripherals();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(`OFS_PER_SET_LO, 32'hffff_ffff, r);
    axi_read(`OFS_PER_STATE_LO, d, r);
    check(d, 32'hffff_ff80);
    axi_write(`OFS_PER_CLEAR_LO, 32'h8000_0080, r);
    check(perLow, 32'h7fff_ff00);
    axi_write(`OFS_PER_SET_HI, 32'hffff_ffff, r);
    check(perHigh, 32'h0000_003f);
    axi_read(`OFS_SYS_SET, d, r);
    check(d, 32'h0000_0000);
    axi_read(`OFS_PER_CLEAR_LO, d, r);
    check(d, 32'h0000_0000);
    check(perLow, 32'h7fff_ff00);
  endtask : test_peripherals

  // guarded writes dropped, violation recorded and cleared by a read
  task automatic test_write_guard();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(`OFS_SYS_SET, 32'h0000_0080, r);
    axi_write(`OFS_GUARD_MODE, 32'h0000_0001, r);
    axi_write(`OFS_SYS_CLEAR, 32'h0000_0080, r);
    check({30'h0, r}, 32'h0000_0000);
    check({31'h0, usbEn}, 32'h0000_0001);
    check({31'h0, guardViol}, 32'h0000_0001);
    axi_read(`OFS_GUARD_STATE, d, r);
    check(d, 32'h0000_0401);
    axi_read(`OFS_GUARD_STATE, d, r);
    check({31'h0, d[0]}, 32'h0000_0000);
    check({31'h0, guardViol}, 32'h0000_0000);
    axi_write(`OFS_GUARD_MODE, 32'h0000_0000, r);
    axi_write(`OFS_SYS_CLEAR, 32'h0000_0080, r);
    check({31'h0, usbEn}, 32'h0000_0000);
  endtask : test_write_guard

  // reserved offset refused on both channels
  task automatic test_reserved();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(16'h000c, 32'hffff_ffff, r);
    check({30'h0, r}, 32'h0000_0002);
    axi_read(16'h000c, d, r);
    check({30'h0, r}, 32'h0000_0002);
    check(d, 32'h0000_0000);
  endtask : test_reserved

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // reset for three cycles, then the scenarios in turn
  initial begin
    reset_n = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = '0;
    araddr  = '0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_reset_values();
    test_system_clocks();
    test_peripherals();
    test_write_guard();
    test_reserved();
    close_out();
  end
endmodule : tb_clock_gate_register_interface
